/* File: rtl/biop_pkg.sv */
package biop_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_FIRST_PINS  = 4'h0; // pin levels, write -> latch
  localparam logic [3:0] ADDR_FIRST_LATCH = 4'h1; // output latch
  localparam logic [3:0] ADDR_FIRST_DIR   = 4'h2; // direction, 1 = input
  localparam logic [3:0] ADDR_FOURTH_PINS = 4'h3;
  localparam logic [3:0] ADDR_FOURTH_LATCH= 4'h4;
  localparam logic [3:0] ADDR_FOURTH_DIR  = 4'h5;
  localparam logic [3:0] ADDR_ANALOG_SEL  = 4'h6; // converter pin select
  localparam logic [3:0] ADDR_CMP_CTRL    = 4'h7; // comparator control
  localparam logic [3:0] ADDR_FIFTH_DIR   = 4'h8; // fifth port direction
  localparam logic [3:0] ADDR_THIRD_DIR   = 4'h9; // third port direction

  // widths
  localparam int PORT_W = 8;

  // reset values
  localparam logic [7:0] DIR_RESET    = 8'hFF; // all inputs
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [7:0] ANALOG_RESET = 8'h2F; // bits 5,3:0 analog
  localparam logic [7:0] CMP_RESET    = 8'h00; // comparators off
  localparam logic [7:0] FIFTH_RESET  = 8'h07; // select bit clear
  localparam logic [7:0] THIRD_RESET  = 8'hFF;

  // masks and field positions
  localparam logic [7:0] ANALOG_MASK  = 8'h2F; // pins able to be analog
  localparam logic [7:0] CMP_IN_MASK  = 8'h0F; // comparator input pins
  localparam logic [7:0] OSC_MASK     = 8'hC0; // oscillator pins 7:6
  localparam int         BIT_TIMER_ZERO_EXT_CLOCK_IN    = 4;     // timer clock / cmp1 output
  localparam int         BIT_PSP_SEL  = 4;     // in fifth port direction
  localparam int         BIT_CMP_ON   = 0;     // comparators enabled
  localparam int         BIT_CMP1_OE  = 1;     // cmp1 output onto pin 4
  localparam int         BIT_HB_OUT   = 5;     // fourth port pwm_out_b pin
  localparam int         BIT_HB_THIRD = 2;     // third port pwm_out_a pin
  localparam int         BIT_PWM_C    = 6;     // fourth port pwm_out_c pin
  localparam int         BIT_PWM_D    = 7;     // fourth port pwm_out_d pin
  localparam logic [7:0] PWM_D_MASK   = 8'hE0; // pins 7:5 carry b,c,d
  localparam logic [7:0] PWM_B_MASK   = 8'h20; // half bridge: only b

  // enhanced pwm output modes
  typedef enum logic [1:0] {
    BIOP_PWM_SINGLE,
    BIOP_PWM_HALF,
    BIOP_PWM_FULL_FWD,
    BIOP_PWM_FULL_REV
  } biop_pwm_mode_t;
endpackage

/* File: rtl/biop_port_pair.sv */
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module biop_port_pair
  import biop_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [7:0]        regRdData,
  // configuration from the oscillator setting
  input  wire logic              oscUsesPins,
  // first port pins
  input  wire logic [PORT_W-1:0] firstPortIn,
  output logic      [PORT_W-1:0] firstPortOut,
  output logic      [PORT_W-1:0] firstPortOe,
  // fourth port pins
  input  wire logic [PORT_W-1:0] fourthPortIn,
  output logic      [PORT_W-1:0] fourthPortOut,
  output logic      [PORT_W-1:0] fourthPortOe,
  // peripheral side
  input  wire logic              comparatorOneOut,
  output logic                   timerZeroExtClockIn,
  output logic      [5:0]        analogPinEnable,
  input  wire logic              pwmActive,
  input  wire biop_pwm_mode_t    pwmMode,
  input  wire logic              pwmOutA,
  input  wire logic              pwmOutB,
  input  wire logic              pwmOutC,
  input  wire logic              pwmOutD,
  output logic                   pwmOutAToThird,
  output logic                   parallelSlaveActive
);

  // gpio register state
  logic [7:0] firstLatch;    // shared latch, both write paths
  logic [7:0] firstDir;      // 1 = input
  logic [7:0] fourthLatch;
  logic [7:0] fourthDir;
  logic [7:0] analogSel;     // converter_control_two pin selects
  logic [7:0] cmpCtrl;       // comparator_control
  logic [7:0] fifthDir;      // holds parallel_slave_select
  logic [7:0] thirdDir;      // only pwm_out_a gating uses it

  // three-stage input samplers
  logic [7:0] firstSyncA, firstSyncB, firstSyncC;
  logic [7:0] fourthSyncA, fourthSyncB, fourthSyncC;
  logic [7:0] firstLevel;    // filtered pin level
  logic [7:0] fourthLevel;

  // peripheral ownership
  logic [7:0] oscMask;       // pins lost to the oscillator
  logic [7:0] analogMask;    // pins in analog mode
  logic [7:0] cmpMask;       // pins held by comparators
  logic [7:0] pwmMask;       // fourth port pins held by pwm
  logic       pwmMulti;      // dual or quad outputs
  logic       cmp1Drive;     // comparator output on bit 4
  logic       pwmDriveB;

  // filtered level: change accepted once stages two and three agree
  function automatic logic [7:0] filt(input logic [7:0] held,
                                      input logic [7:0] b,
                                      input logic [7:0] c);
    filt = (b & c) | (held & (b | c));
  endfunction

  // hit test for a register write
  function automatic logic wrHit(input logic [3:0] a);
    wrHit = regWrite && (regAddr == a);
  endfunction

  // first port latch: pin-register or latch writes, last wins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      firstLatch <= LATCH_RESET;
    end else if (wrHit(ADDR_FIRST_PINS) || wrHit(ADDR_FIRST_LATCH)) begin
      firstLatch <= regWrData;
    end
  end

  // first port direction register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      firstDir <= DIR_RESET;
    end else if (wrHit(ADDR_FIRST_DIR)) begin
      firstDir <= regWrData;
    end
  end

  // fourth port latch, same two write paths
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fourthLatch <= LATCH_RESET;
    end else if (wrHit(ADDR_FOURTH_PINS) || wrHit(ADDR_FOURTH_LATCH)) begin
      fourthLatch <= regWrData;
    end
  end

  // fourth port direction, every bit on its own
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fourthDir <= DIR_RESET;
    end else if (wrHit(ADDR_FOURTH_DIR)) begin
      fourthDir <= regWrData;
    end
  end

  // peripheral configuration registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      analogSel <= ANALOG_RESET;
      cmpCtrl   <= CMP_RESET;
      fifthDir  <= FIFTH_RESET;
      thirdDir  <= THIRD_RESET;
    end else begin
      if (wrHit(ADDR_ANALOG_SEL)) begin
        analogSel <= regWrData & ANALOG_MASK;
      end
      if (wrHit(ADDR_CMP_CTRL)) begin
        cmpCtrl <= regWrData;
      end
      if (wrHit(ADDR_FIFTH_DIR)) begin
        fifthDir <= regWrData;
      end
      if (wrHit(ADDR_THIRD_DIR)) begin
        thirdDir <= regWrData;
      end
    end
  end

  // pin samplers; stage one feeds only stage two
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      firstSyncA  <= 8'h00;
      firstSyncB  <= 8'h00;
      firstSyncC  <= 8'h00;
      fourthSyncA <= 8'h00;
      fourthSyncB <= 8'h00;
      fourthSyncC <= 8'h00;
      firstLevel  <= 8'h00;
      fourthLevel <= 8'h00;
    end else begin
      firstSyncA  <= firstPortIn;
      firstSyncB  <= firstSyncA;
      firstSyncC  <= firstSyncB;
      fourthSyncA <= fourthPortIn;
      fourthSyncB <= fourthSyncA;
      fourthSyncC <= fourthSyncB;
      firstLevel  <= filt(firstLevel, firstSyncB, firstSyncC);
      fourthLevel <= filt(fourthLevel, fourthSyncB, fourthSyncC);
    end
  end

  // who owns which pin
  always_comb begin
    oscMask    = oscUsesPins ? OSC_MASK : 8'h00;
    analogMask = analogSel & ANALOG_MASK;
    // comparators on: low four pins are not digital inputs
    cmpMask    = cmpCtrl[BIT_CMP_ON] ? CMP_IN_MASK : 8'h00;
    cmp1Drive  = cmpCtrl[BIT_CMP_ON] && cmpCtrl[BIT_CMP1_OE];
    pwmMulti   = pwmActive && (pwmMode != BIOP_PWM_SINGLE);
    pwmMask    = 8'h00;
    if (pwmActive) begin
      unique case (pwmMode)
        BIOP_PWM_SINGLE:   pwmMask = 8'h00;
        BIOP_PWM_HALF:     pwmMask = PWM_B_MASK;
        BIOP_PWM_FULL_FWD,
        BIOP_PWM_FULL_REV: pwmMask = PWM_D_MASK;
      endcase
    end
    pwmDriveB = pwmOutB;
  end

  // first port drivers; direction still gates analog pins
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      firstPortOe[i]  = !firstDir[i] && !oscMask[i];
      firstPortOut[i] = firstLatch[i];
    end
    // comparator output replaces the latch on bit 4
    if (cmp1Drive) begin
      firstPortOut[BIT_TIMER_ZERO_EXT_CLOCK_IN] = comparatorOneOut;
    end
  end

  // fourth port drivers; pwm takes its pins
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      fourthPortOe[i]  = !fourthDir[i];
      fourthPortOut[i] = fourthLatch[i];
    end
    // pwm pins still need their direction bit clear to drive
    if (pwmMask[BIT_HB_OUT]) begin
      fourthPortOut[BIT_HB_OUT] = pwmDriveB;
    end
    if (pwmMask[BIT_PWM_C]) begin
      fourthPortOut[BIT_PWM_C] = pwmOutC;
    end
    if (pwmMask[BIT_PWM_D]) begin
      fourthPortOut[BIT_PWM_D] = pwmOutD;
    end
  end

  // pwm_out_a leaves through the third port pin
  assign pwmOutAToThird = pwmOutA && pwmActive
                          && !thirdDir[BIT_HB_THIRD];

  // slave port mode, blocked by multi-output pwm
  assign parallelSlaveActive = fifthDir[BIT_PSP_SEL] && !pwmMulti;

  // converter sees the pins that are selected analog
  assign analogPinEnable = analogMask[5:0];

  // timer clock comes from the filtered bit-4 level
  assign timerZeroExtClockIn = firstLevel[BIT_TIMER_ZERO_EXT_CLOCK_IN];

  // read data, one cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        // analog, comparator and oscillator pins read zero
        ADDR_FIRST_PINS:   regRdData <= firstLevel
                             & ~analogMask & ~cmpMask & ~oscMask;
        ADDR_FIRST_LATCH:  regRdData <= firstLatch & ~oscMask;
        ADDR_FIRST_DIR:    regRdData <= firstDir & ~oscMask;
        ADDR_FOURTH_PINS:  regRdData <= fourthLevel;
        ADDR_FOURTH_LATCH: regRdData <= fourthLatch;
        ADDR_FOURTH_DIR:   regRdData <= fourthDir;
        ADDR_ANALOG_SEL:   regRdData <= analogSel;
        ADDR_CMP_CTRL:     regRdData <= cmpCtrl;
        ADDR_FIFTH_DIR:    regRdData <= fifthDir;
        ADDR_THIRD_DIR:    regRdData <= thirdDir;
        default:           regRdData <= 8'h00; // unmapped reads zero
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // write to pin register lands in the latch on the next edge
  property p_pinwrite_latch;
    @(posedge clock) disable iff (!reset_n)
      (regWrite && regAddr == ADDR_FIRST_PINS)
        |=> firstLatch == $past(regWrData);
  endproperty
  a_pinwrite_latch: assert property (p_pinwrite_latch)
    else $error("pin register write did not reach latch");

  // latch read returns the latch, not the pins
  property p_latch_read;
    @(posedge clock) disable iff (!reset_n)
      (regRead && regAddr == ADDR_FOURTH_LATCH && !regWrite)
        |=> regRdData == fourthLatch;
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read returned wrong value");

  // input direction never drives
  property p_input_hiz;
    @(posedge clock) disable iff (!reset_n)
      (fourthPortOe & fourthDir) == 8'h00;
  endproperty
  a_input_hiz: assert property (p_input_hiz)
    else $error("input pin is being driven");

  // output direction drives the latch on plain gpio pins
  property p_output_drive;
    @(posedge clock) disable iff (!reset_n)
      (!firstDir[0] && !oscUsesPins) |-> firstPortOe[0]
        && firstPortOut[0] == firstLatch[0];
  endproperty
  a_output_drive: assert property (p_output_drive)
    else $error("output pin not driven from latch");

  // oscillator pins read zero
  property p_osc_zero;
    @(posedge clock) disable iff (!reset_n)
      (regRead && oscUsesPins && regAddr == ADDR_FIRST_DIR) ##1
        $stable(oscUsesPins) |-> (regRdData & OSC_MASK) == 8'h00;
  endproperty
  a_osc_zero: assert property (p_osc_zero)
    else $error("oscillator pin bits not zero");

  // after reset the analog pins are selected
  property p_reset_analog;
    @(posedge clock) !reset_n |=> analogSel == ANALOG_RESET
      && fourthDir == DIR_RESET;
  endproperty
  a_reset_analog: assert property (p_reset_analog)
    else $error("reset defaults wrong");

  // multi-output pwm blocks the slave port
  property p_pwm_blocks_psp;
    @(posedge clock) disable iff (!reset_n)
      pwmMulti |-> !parallelSlaveActive;
  endproperty
  a_pwm_blocks_psp: assert property (p_pwm_blocks_psp)
    else $error("slave port active under multi pwm");

  // both write paths share one latch, last write wins
  property p_shared_latch;
    @(posedge clock) disable iff (!reset_n)
      (regWrite && regAddr == ADDR_FIRST_LATCH) ##1
      (regWrite && regAddr == ADDR_FIRST_PINS)
        |=> firstLatch == $past(regWrData);
  endproperty
  a_shared_latch: assert property (p_shared_latch)
    else $error("latch not from most recent write");

  // comparator output owns bit 4 while routed there
  property p_cmp1_pin;
    @(posedge clock) disable iff (!reset_n)
      (cmpCtrl[BIT_CMP_ON] && cmpCtrl[BIT_CMP1_OE])
        |-> firstPortOut[BIT_TIMER_ZERO_EXT_CLOCK_IN] == comparatorOneOut;
  endproperty
  a_cmp1_pin: assert property (p_cmp1_pin)
    else $error("comparator output missing on bit 4");

  // oscillator pins never driven, whatever the direction bits say
  property p_osc_no_drive;
    @(posedge clock) disable iff (!reset_n)
      oscUsesPins |-> (firstPortOe & OSC_MASK) == 8'h00;
  endproperty
  a_osc_no_drive: assert property (p_osc_no_drive)
    else $error("oscillator pin driven as gpio");

  // both bridge modes put pwm_out_b on bit 5, not the latch
  property p_pwm_b_pin;
    @(posedge clock) disable iff (!reset_n)
      (pwmActive && pwmMode != BIOP_PWM_SINGLE)
        |-> fourthPortOut[BIT_HB_OUT] == pwmOutB;
  endproperty
  a_pwm_b_pin: assert property (p_pwm_b_pin)
    else $error("pwm_out_b not on its pin");

  // analog pins read zero through the pin register
  property p_analog_read_zero;
    @(posedge clock) disable iff (!reset_n)
      (regRead && regAddr == ADDR_FIRST_PINS)
        |=> (regRdData & $past(analogSel)) == 8'h00;
  endproperty
  a_analog_read_zero: assert property (p_analog_read_zero)
    else $error("analog pin read back nonzero");

  // each fourth port direction bit steers its own driver
  property p_fourth_dir_write;
    @(posedge clock) disable iff (!reset_n)
      (regWrite && regAddr == ADDR_FOURTH_DIR)
        |=> fourthDir == $past(regWrData) && fourthPortOe == ~fourthDir;
  endproperty
  a_fourth_dir_write: assert property (p_fourth_dir_write)
    else $error("fourth port direction write not applied");

endmodule

/* File: bench/biop_pin_model.sv */
`timescale 1ns/1ps
// external circuitry on one eight-bit port
module biop_pin_model
  import biop_pkg::*;
(
  // device side of the pins
  input  wire logic [PORT_W-1:0] pinOut,
  input  wire logic [PORT_W-1:0] pinOe,
  // level the outside world drives
  input  wire logic [PORT_W-1:0] extDrive,
  // resolved pin level back to the device
  output logic      [PORT_W-1:0] pinLevel
);
  // per bit: an enabled device driver wins, else the outside level
  // outside drivers yield rather than fight, so no contention modelled
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : extDrive[i];
    end
  end
endmodule

/* File: bench/bidirectional_io_port_pair_bench.sv */
`timescale 1ns/1ps
module bidirectional_io_port_pair_bench;
  import biop_pkg::*;
  // clock, reset and register port
  logic           clock     = 1'b0;
  logic           reset_n   = 1'b0;
  logic [3:0]     regAddr   = 4'h0;
  logic [7:0]     regWrData = 8'h00;
  logic           regWrite  = 1'b0;
  logic           regRead   = 1'b0;
  logic [7:0]     regRdData;
  // pins and peripherals
  logic           oscUses   = 1'b0;
  logic [7:0]     aIn, aOut, aOe, dIn, dOut, dOe;
  logic [7:0]     aExt      = 8'hFF;
  logic [7:0]     dExt      = 8'hFF;
  logic           cmpOut    = 1'b1;
  logic           tmrClk, pwmAThird, slave;
  logic [5:0]     anaEn;
  logic           pwmOn     = 1'b0;
  biop_pwm_mode_t pwmMode   = BIOP_PWM_SINGLE;
  logic           pwmA      = 1'b1;
  logic           pwmB      = 1'b1;
  logic           pwmC      = 1'b0;
  logic           pwmD      = 1'b1;
  // bookkeeping
  int             badCount  = 0;
  int             compares  = 0;

  always #12.5 clock = ~clock;

  biop_port_pair uut (
    .clock(clock), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .oscUsesPins(oscUses),
    .firstPortIn(aIn), .firstPortOut(aOut), .firstPortOe(aOe),
    .fourthPortIn(dIn), .fourthPortOut(dOut), .fourthPortOe(dOe),
    .comparatorOneOut(cmpOut), .timerZeroExtClockIn(tmrClk),
    .analogPinEnable(anaEn), .pwmActive(pwmOn), .pwmMode(pwmMode),
    .pwmOutA(pwmA), .pwmOutB(pwmB), .pwmOutC(pwmC), .pwmOutD(pwmD),
    .pwmOutAToThird(pwmAThird), .parallelSlaveActive(slave));
  biop_pin_model firstPins (
    .pinOut(aOut), .pinOe(aOe), .extDrive(aExt), .pinLevel(aIn));
  biop_pin_model fourthPins (
    .pinOut(dOut), .pinOe(dOe), .extDrive(dExt), .pinLevel(dIn));

  // one comparison, counted
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clock);
    regWrite  <= 1'b0;
  endtask

  // two writes on back-to-back cycles, strobe held between them
  task automatic wrPair(input logic [3:0] a0, input logic [7:0] d0,
                        input logic [3:0] a1, input logic [7:0] d1);
    @(posedge clock);
    regAddr   <= a0;
    regWrData <= d0;
    regWrite  <= 1'b1;
    @(posedge clock);
    regAddr   <= a1;
    regWrData <= d1;
    @(posedge clock);
    regWrite  <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk("regRdData", exp, regRdData);
  endtask

  // let edges pass; pin filter needs several
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic summarize();
    $display("compares %0d badCount %0d", compares, badCount);
    if (badCount == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #(25 * 8000);
    badCount++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    // power-on state
    rd(ADDR_FIRST_LATCH, 8'h00);
    rd(ADDR_FIRST_DIR, 8'hFF);
    rd(ADDR_FOURTH_LATCH, 8'h00);
    rd(ADDR_FOURTH_DIR, 8'hFF);
    rd(ADDR_ANALOG_SEL, 8'h2F);
    rd(ADDR_CMP_CTRL, 8'h00);
    rd(ADDR_FIFTH_DIR, 8'h07);
    rd(ADDR_THIRD_DIR, 8'hFF);
    rd(ADDR_FIRST_PINS, 8'hD0);
    rd(ADDR_FOURTH_PINS, 8'hFF);
    settle(1);
    chk("rdIdle", 8'h00, regRdData);
    chk("firstOe", 8'h00, aOe);
    chk("fourthOe", 8'h00, dOe);
    rd(4'hF, 8'h00);
    $display("test reset done");
    // analog select while the directions stay set
    wr(ADDR_ANALOG_SEL, 8'hFF);
    rd(ADDR_ANALOG_SEL, 8'h2F);
    chk("anaEn", 8'h2F, {2'h0, anaEn});
    chk("analogOe", 8'h00, aOe);
    wr(ADDR_ANALOG_SEL, 8'h00);
    // directions, latch, both write paths
    wr(ADDR_FIRST_DIR, 8'h00);
    settle(1);
    chk("firstOe", 8'hFF, aOe);
    wr(ADDR_FIRST_PINS, 8'h55);
    wr(ADDR_FIRST_LATCH, 8'hA3);
    wrPair(ADDR_FIRST_LATCH, 8'h55, ADDR_FIRST_PINS, 8'hA3);
    settle(1);
    chk("firstOut", 8'hA3, aOut);
    rd(ADDR_FIRST_LATCH, 8'hA3);
    wr(ADDR_FIRST_DIR, 8'hF0);
    aExt <= 8'hFC;
    settle(8);
    rd(ADDR_FIRST_PINS, 8'hF3);
    rd(ADDR_FIRST_LATCH, 8'hA3);
    $display("test latch done");
    // oscillator owns the top two pins
    @(posedge clock);
    oscUses <= 1'b1;
    settle(1);
    rd(ADDR_FIRST_LATCH, 8'h23);
    wr(ADDR_FIRST_DIR, 8'h30);
    settle(1);
    chk("oscOe", 8'h0F, aOe);
    rd(ADDR_FIRST_DIR, 8'h30);
    rd(ADDR_FIRST_PINS, 8'h33);
    wr(ADDR_FIRST_DIR, 8'hF0);
    @(posedge clock);
    oscUses <= 1'b0;
    // comparators on: low pins no longer digital
    wr(ADDR_CMP_CTRL, 8'h01);
    rd(ADDR_FIRST_PINS, 8'hF0);
    wr(ADDR_FIRST_DIR, 8'hEF);
    wr(ADDR_CMP_CTRL, 8'h03);
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      cmpOut <= v[0];
      settle(1);
      chk("cmpPin", {7'h00, v[0]}, {7'h00, aOut[4]});
    end
    // bit4 feeds the timer clock input
    wr(ADDR_CMP_CTRL, 8'h00);
    wr(ADDR_FIRST_DIR, 8'hFF);
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      aExt <= {3'h7, v[0], 4'hC};
      settle(8);
      chk("tmrClk", {7'h00, v[0]}, {7'h00, tmrClk});
    end
    $display("test sharing done");
    // fourth port directions and pwm outputs
    wr(ADDR_FOURTH_DIR, 8'h0F);
    wr(ADDR_FOURTH_LATCH, 8'h5A);
    settle(1);
    chk("fourthOe", 8'hF0, dOe);
    chk("fourthOut", 8'h50, dOut & 8'hF0);
    @(posedge clock);
    pwmOn   <= 1'b1;
    pwmMode <= BIOP_PWM_HALF;
    settle(1);
    chk("pwmHalf", 8'h70, dOut & 8'hF0);
    @(posedge clock);
    pwmMode <= BIOP_PWM_FULL_FWD;
    settle(1);
    chk("pwmFull", 8'hA0, dOut & 8'hE0);
    chk("pwmA", 8'h00, {7'h00, pwmAThird});
    wr(ADDR_THIRD_DIR, 8'hFB);
    settle(1);
    chk("pwmA", 8'h01, {7'h00, pwmAThird});
    // slave port select against pwm modes
    wr(ADDR_FIFTH_DIR, 8'h17);
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      pwmMode <= biop_pwm_mode_t'(m);
      settle(1);
      chk("slave", {7'h00, m == 0}, {7'h00, slave});
      if (m > 1) begin
        chk("pwmFull", 8'hA0, dOut & 8'hE0);
      end
    end
    @(posedge clock);
    pwmOn <= 1'b0;
    settle(1);
    chk("slave", 8'h01, {7'h00, slave});
    $display("test fourth port done");
    summarize();
  end
endmodule
